// file: dv/jtag_host_model.sv
`timescale 1ns/10ps
module jtag_host_model
    import jtag_mem_pkg::*;
(
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    input wire logic i_tdo,
    input wire logic i_tdo_oe
);
    // Phase level the host wants; TDI carries it whenever the tap sits in Idle
    logic phase = 1'b0;
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // TCK only runs inside these tasks and rests low between them
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #16;
        // A released TDO floats up to its pull-up level
        tdo = i_tdo_oe ? i_tdo : 1'b1;
        o_tck = 1'b1;
        #16;
        o_tck = 1'b0;
    endtask
    // From Idle through one IR or DR scan, MSB first, back to Idle
    task automatic scan(input logic is_ir, input logic [19:0] din, input int n,
                        output logic [19:0] dout);
        logic b;
        dout = '0;
        tick(1'b1, phase, b);
        if (is_ir) begin
            tick(1'b1, phase, b);
        end
        tick(1'b0, phase, b);
        tick(1'b0, phase, b);
        for (int i = n - 1; i >= 0; i--) begin
            tick(i == 0, din[i], b);
            dout[i] = b;
        end
        tick(1'b1, phase, b);
        tick(1'b0, phase, b);
    endtask
    task automatic idle(input int n);
        logic b;
        for (int i = 0; i < n; i++) begin
            tick(1'b0, phase, b);
        end
    endtask
    // Settling cycles before the edge let the last update cross to the bus side
    task automatic set_phase(input logic lvl);
        idle(3);
        phase = lvl;
        idle(10);
    endtask
    task automatic tap_reset();
        logic b;
        for (int i = 0; i < 6; i++) begin
            tick(1'b1, phase, b);
        end
        tick(1'b0, phase, b);
    endtask
endmodule // jtag_host_model

// file: dv/jtag_memory_bus_access_tb_top.sv
`timescale 1ns/10ps
module jtag_memory_bus_access_tb_top;
    import jtag_mem_pkg::*;
    logic i_clk_sys;
    logic i_rst;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic phase_out;
    logic hold;
    mem_req_s mem;
    mem_req_s last_wr;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] memory_data_bus;
    int n_errors = 0;
    int n_tests = 0;
    int wr_cnt = 0;
    int rd_cnt = 0;

    jtag_memory_bus_access jtag_memory_bus_access_inst (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_mem(mem), .i_mem_rdata(rdata), .o_mdb(memory_data_bus),
        .o_test_clock_phase(phase_out), .o_debug_hold(hold)
    );
    jtag_host_model jtag_host_model_inst (
        .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo), .i_tdo_oe(tdo_oe)
    );
    ////////////////////////////////////////////////////////////////////////////////
    // Memory content is a fixed function of the address, so reads need no storage
    function automatic logic [DATA_W-1:0] mem_val(input logic [ADDR_W-1:0] a);
        return a[15:0] ^ {a[19:16], 12'h5a3};
    endfunction
    assign rdata = mem_val(mem.addr);
    always @(posedge i_clk_sys) begin
        if (mem.wr === 1'b1) begin
            wr_cnt++;
            last_wr = mem;
        end
        if (mem.rd === 1'b1) begin
            rd_cnt++;
        end
    end
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic t_reset_values();
        logic [19:0] d;
        @(negedge i_clk_sys);
        chk("bus after reset", 40'(mem), 40'h0);
        chk("data bus after reset", 40'(memory_data_bus), 40'h0);
        chk("hold after reset", 40'(hold), 40'h0);
        chk("phase after reset", 40'(phase_out), 40'h0);
        chk("drive enable idle", 40'(tdo_oe), 40'h0);
        jtag_host_model_inst.scan(1'b1, 20'(IR_BYPASS), IR_W, d);
        chk("ir capture", 40'(d), 40'(IR_CAPTURE_VAL));
        $display("test reset values done");
    endtask
    task automatic t_write(input logic [15:0] ctrl, input logic [19:0] addr, input int aw,
                           input logic [15:0] data, input logic v2);
        logic [19:0] d;
        int n0;
        n0 = wr_cnt;
        jtag_host_model_inst.set_phase(1'b0);
        jtag_host_model_inst.scan(1'b1, 20'(IR_CTRL_WRITE), IR_W, d);
        jtag_host_model_inst.scan(1'b0, 20'(ctrl), DATA_W, d);
        jtag_host_model_inst.scan(1'b1, 20'(IR_LOAD_ADDR), IR_W, d);
        jtag_host_model_inst.scan(1'b0, addr, aw, d);
        if (v2) begin
            jtag_host_model_inst.set_phase(1'b1);
        end
        jtag_host_model_inst.scan(1'b1, 20'(DATA_TO_ADDRESS_INSTR), IR_W, d);
        jtag_host_model_inst.scan(1'b0, 20'(data), DATA_W, d);
        jtag_host_model_inst.set_phase(!v2);
        @(negedge i_clk_sys);
        chk("store count", 40'(wr_cnt - n0), 40'd1);
        chk("store address", 40'(last_wr.addr), 40'(addr));
        chk("store data", 40'(last_wr.wdata), 40'(data));
        chk("byte select", 40'(last_wr.byte_sel), 40'(ctrl[CTRL_BYTE_BIT]));
        chk("data bus", 40'(memory_data_bus), 40'(data));
        chk("hold level", 40'(hold), 40'(ctrl[CTRL_HOLD_BIT]));
        if (v2) begin
            jtag_host_model_inst.scan(1'b1, 20'(IR_CTRL_WRITE), IR_W, d);
            jtag_host_model_inst.scan(1'b0, 20'h00501, DATA_W, d);
            jtag_host_model_inst.set_phase(1'b1);
            jtag_host_model_inst.set_phase(1'b0);
            jtag_host_model_inst.set_phase(1'b1);
            @(negedge i_clk_sys);
            chk("hold after pulse", 40'(hold), 40'd1);
            chk("no extra store", 40'(wr_cnt - n0), 40'd1);
        end
        $display("test write ctrl %h addr %h done", ctrl, addr);
    endtask
    task automatic t_read(input logic [19:0] a1, input logic [19:0] a2);
        logic [19:0] d;
        int n0;
        int w0;
        jtag_host_model_inst.set_phase(1'b0);
        jtag_host_model_inst.scan(1'b1, 20'(IR_CTRL_WRITE), IR_W, d);
        jtag_host_model_inst.scan(1'b0, 20'h02409, DATA_W, d);
        jtag_host_model_inst.scan(1'b1, 20'(IR_LOAD_ADDR), IR_W, d);
        jtag_host_model_inst.scan(1'b0, a1, ADDR_W, d);
        jtag_host_model_inst.scan(1'b1, 20'(DATA_TO_ADDRESS_INSTR), IR_W, d);
        n0 = rd_cnt;
        w0 = wr_cnt;
        jtag_host_model_inst.set_phase(1'b1);
        @(negedge i_clk_sys);
        chk("phase level", 40'(phase_out), 40'd1);
        chk("read count", 40'(rd_cnt - n0), 40'd1);
        chk("read data bus", 40'(memory_data_bus), 40'(mem_val(a1)));
        jtag_host_model_inst.scan(1'b0, 20'h0, DATA_W, d);
        chk("read shift out", 40'(d), 40'(mem_val(a1)));
        // Address loaded while the phase is high must wait for the phase to fall
        jtag_host_model_inst.scan(1'b1, 20'(IR_LOAD_ADDR), IR_W, d);
        jtag_host_model_inst.scan(1'b0, a2, ADDR_W, d);
        @(negedge i_clk_sys);
        chk("address held", 40'(mem.addr), 40'(a1));
        jtag_host_model_inst.set_phase(1'b0);
        @(negedge i_clk_sys);
        chk("address applied", 40'(mem.addr), 40'(a2));
        jtag_host_model_inst.scan(1'b1, 20'(DATA_TO_ADDRESS_INSTR), IR_W, d);
        jtag_host_model_inst.set_phase(1'b1);
        @(negedge i_clk_sys);
        chk("second read", 40'(memory_data_bus), 40'(mem_val(a2)));
        chk("no store on read", 40'(wr_cnt - w0), 40'd0);
        $display("test read done");
    endtask
    task automatic t_bypass();
        logic [19:0] d;
        mem_req_s m0;
        m0 = mem;
        jtag_host_model_inst.scan(1'b1, 20'(IR_BYPASS), IR_W, d);
        jtag_host_model_inst.scan(1'b0, 20'h0a5c3, DATA_W, d);
        chk("bypass delay", 40'(d), 40'h0052e1);
        @(negedge i_clk_sys);
        chk("bus untouched", 40'(mem), 40'(m0));
        $display("test bypass done");
    endtask
    // Hand-back at the end of access: control word returns to its reset value
    task automatic t_release();
        logic [19:0] d;
        int w0;
        w0 = wr_cnt;
        jtag_host_model_inst.scan(1'b1, 20'(IR_CTRL_WRITE), IR_W, d);
        jtag_host_model_inst.scan(1'b0, 20'(CTRL_RESET), DATA_W, d);
        chk("control read back", 40'(d), 40'h2409);
        jtag_host_model_inst.idle(3);
        @(negedge i_clk_sys);
        chk("hold released", 40'(hold), 40'd0);
        chk("no store on release", 40'(wr_cnt - w0), 40'd0);
        $display("test release done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        i_rst = 1'b1;
        fork
            jtag_host_model_inst.idle(6);
            repeat (8) @(negedge i_clk_sys);
        join
        @(negedge i_clk_sys);
        i_rst = 1'b0;
        jtag_host_model_inst.idle(3);
        jtag_host_model_inst.tap_reset();
        t_reset_values();
        t_write(16'h2408, 20'h01234, 16, 16'hbeef, 1'b0);
        t_write(16'h2418, 20'h00201, 16, 16'h00a5, 1'b0);
        t_write(16'h2408, 20'habcde, 20, 16'h1357, 1'b0);
        t_write(16'h0510, 20'h12344, 20, 16'hc3c3, 1'b1);
        t_read(20'h01234, 20'habcde);
        t_bypass();
        t_release();
        report_and_stop();
    end
endmodule // jtag_memory_bus_access_tb_top

// file: pkg/jtag_mem_pkg.sv
package jtag_mem_pkg;

    // Widths of the scan registers and of the memory side
    localparam int IR_W = 8;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int ADDR_SHORT_W = 16;

    // Instruction codes; the values are arbitrary choices for this block
    localparam logic [IR_W-1:0] IR_LOAD_ADDR = 8'h41;
    localparam logic [IR_W-1:0] DATA_TO_ADDRESS_INSTR = 8'h42;
    localparam logic [IR_W-1:0] IR_CTRL_WRITE = 8'h43;
    localparam logic [IR_W-1:0] IR_BYPASS = 8'hff;
    localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 8'h01;

    // Control signal register fields and reset value
    localparam int CTRL_RW_BIT = 0;
    localparam int CTRL_BYTE_BIT = 4;
    localparam int CTRL_HOLD_BIT = 10;
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0001;

    localparam logic [ADDR_W-1:0] ADDR_ZERO = 20'h00000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

    // Synchroniser lanes, link domain to system domain
    localparam int SY_ADDR = 0;
    localparam int SY_DATA = 1;
    localparam int SY_CTRL = 2;
    localparam int SY_TEST_CLOCK_PHASE = 3;
    localparam int SY_D2A = 4;
    localparam int SY_W = 5;

    typedef enum logic [15:0] {
        TAP_RESET      = 16'h0001,
        TAP_IDLE       = 16'h0002,
        TAP_SEL_DR     = 16'h0004,
        TAP_CAP_DR     = 16'h0008,
        TAP_SHIFT_DR   = 16'h0010,
        TAP_EXIT1_DR   = 16'h0020,
        TAP_PAUSE_DR   = 16'h0040,
        TAP_EXIT2_DR   = 16'h0080,
        TAP_UPDATE_DR  = 16'h0100,
        TAP_SEL_IR     = 16'h0200,
        TAP_CAP_IR     = 16'h0400,
        TAP_SHIFT_IR   = 16'h0800,
        TAP_EXIT1_IR   = 16'h1000,
        TAP_PAUSE_IR   = 16'h2000,
        TAP_EXIT2_IR   = 16'h4000,
        TAP_UPDATE_IR  = 16'h8000
    } tap_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
        logic byte_sel;
    } mem_req_s;

endpackage

// file: verilog/jtag_memory_bus_access.sv
`timescale 1ns/10ps
// Functional notes
// - Address loaded by load_address_instr while test_clock_phase low reaches memory.
// - Read: rising test_clock_phase under data_to_address_instr puts data on bus.
// - With test_clock_phase low again a new address is accepted.
// - Write: shifted data drives data bus, stored on next phase edge, rising or falling.
// - Address shift is twenty bits on extended, sixteen on base.
// - After such a write, 0x0501 and a phase pulse return to hold.
module jtag_memory_bus_access
    import jtag_mem_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_oe,
    output mem_req_s o_mem,
    input wire logic [DATA_W-1:0] i_mem_rdata,
    output logic [DATA_W-1:0] o_mdb,
    output logic o_test_clock_phase,
    output logic o_debug_hold
);

    ////////////////////////////////////////////////////////////////////////////
    // Link clock domain: reset synchroniser and tap controller

    logic rst_tck_meta;
    logic rst_tck;
    tap_state_e tap_state;

    always_ff @(posedge i_tck) begin
        rst_tck_meta <= i_rst;
        rst_tck <= rst_tck_meta;
    end

    jtag_tap_fsm u_tap (
        .i_tck(i_tck),
        .i_rst_tck(rst_tck),
        .i_tms(i_tms),
        .o_state(tap_state)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Link clock domain: instruction and data scan registers

    logic [IR_W-1:0] ir, next_ir;
    logic [IR_W-1:0] instruction_shift, next_instruction_shift;
    logic [ADDR_W-1:0] dr_shift, next_dr_shift;
    logic [ADDR_W-1:0] addr_hold, next_addr_hold;
    logic [DATA_W-1:0] data_hold, next_data_hold;
    logic [DATA_W-1:0] ctrl_hold, next_ctrl_hold;
    logic [DATA_W-1:0] rd_copy, next_rd_copy;
    logic test_clock_phase, next_test_clock_phase;
    logic d2a, next_d2a;
    logic tog_addr, next_tog_addr;
    logic tog_data, next_tog_data;
    logic tog_ctrl, next_tog_ctrl;
    logic rd_tog_meta, rd_tog_s, rd_tog_d;
    logic rd_tog;
    logic sel_addr, sel_data, sel_ctrl;

    assign sel_addr = (ir == IR_LOAD_ADDR);
    assign sel_data = (ir == DATA_TO_ADDRESS_INSTR);
    assign sel_ctrl = (ir == IR_CTRL_WRITE);

    always_comb begin
        next_ir = ir;
        next_instruction_shift = instruction_shift;
        next_dr_shift = dr_shift;
        next_addr_hold = addr_hold;
        next_data_hold = data_hold;
        next_ctrl_hold = ctrl_hold;
        next_rd_copy = rd_copy;
        next_test_clock_phase = test_clock_phase;
        next_tog_addr = tog_addr;
        next_tog_data = tog_data;
        next_tog_ctrl = tog_ctrl;
        // Read data is quasi-static once its toggle has crossed over
        if (rd_tog_s != rd_tog_d) begin
            next_rd_copy = o_mdb;
        end
        unique case (tap_state)
            TAP_RESET: next_ir = IR_BYPASS;
            // The phase level follows TDI while the tap idles
            TAP_IDLE: next_test_clock_phase = i_tdi;
            TAP_CAP_IR: next_instruction_shift = IR_CAPTURE_VAL;
            TAP_SHIFT_IR: next_instruction_shift = {instruction_shift[IR_W-2:0], i_tdi};
            TAP_UPDATE_IR: next_ir = instruction_shift;
            TAP_CAP_DR: begin
                if (sel_data) begin
                    next_dr_shift = ADDR_W'(rd_copy);
                end else if (sel_ctrl) begin
                    next_dr_shift = ADDR_W'(ctrl_hold);
                end else begin
                    // Zero capture lets a short address shift leave the top bits clear
                    next_dr_shift = ADDR_ZERO;
                end
            end
            TAP_SHIFT_DR: next_dr_shift = {dr_shift[ADDR_W-2:0], i_tdi};
            TAP_UPDATE_DR: begin
                if (sel_addr) begin
                    next_addr_hold = dr_shift;
                    next_tog_addr = ~tog_addr;
                end else if (sel_data) begin
                    next_data_hold = dr_shift[DATA_W-1:0];
                    next_tog_data = ~tog_data;
                end else if (sel_ctrl) begin
                    next_ctrl_hold = dr_shift[DATA_W-1:0];
                    next_tog_ctrl = ~tog_ctrl;
                end
            end
            default: begin
            end
        endcase
        next_d2a = (next_ir == DATA_TO_ADDRESS_INSTR);
    end

    always_ff @(posedge i_tck) begin
        if (rst_tck) begin
            ir <= IR_BYPASS;
            instruction_shift <= IR_CAPTURE_VAL;
            dr_shift <= ADDR_ZERO;
            addr_hold <= ADDR_ZERO;
            data_hold <= DATA_ZERO;
            ctrl_hold <= CTRL_RESET;
            rd_copy <= DATA_ZERO;
            test_clock_phase <= 1'b0;
            d2a <= 1'b0;
            tog_addr <= 1'b0;
            tog_data <= 1'b0;
            tog_ctrl <= 1'b0;
            rd_tog_meta <= 1'b0;
            rd_tog_s <= 1'b0;
            rd_tog_d <= 1'b0;
        end else begin
            ir <= next_ir;
            instruction_shift <= next_instruction_shift;
            dr_shift <= next_dr_shift;
            addr_hold <= next_addr_hold;
            data_hold <= next_data_hold;
            ctrl_hold <= next_ctrl_hold;
            rd_copy <= next_rd_copy;
            test_clock_phase <= next_test_clock_phase;
            d2a <= next_d2a;
            tog_addr <= next_tog_addr;
            tog_data <= next_tog_data;
            tog_ctrl <= next_tog_ctrl;
            rd_tog_meta <= rd_tog;
            rd_tog_s <= rd_tog_meta;
            rd_tog_d <= rd_tog_s;
        end
    end

    // Output bit depends on the register in the scan path
    always_comb begin
        o_tdo_oe = (tap_state == TAP_SHIFT_DR) || (tap_state == TAP_SHIFT_IR);
        if (tap_state == TAP_SHIFT_IR) begin
            o_tdo = instruction_shift[IR_W-1];
        end else if (sel_addr) begin
            o_tdo = dr_shift[ADDR_W-1];
        end else if (sel_data || sel_ctrl) begin
            o_tdo = dr_shift[DATA_W-1];
        end else begin
            o_tdo = dr_shift[0];
        end
    end

    property p_addr_update;
        @(posedge i_tck) disable iff (rst_tck)
        (tap_state == TAP_UPDATE_DR && sel_addr) |=> (addr_hold == $past(dr_shift));
    endproperty
    a_addr_update: assert property (p_addr_update)
        else $error("address hold not loaded from scan");
    property p_ctrl_routing;
        @(posedge i_tck) disable iff (rst_tck)
        (tap_state == TAP_UPDATE_DR && !sel_ctrl) |=> $stable(ctrl_hold);
    endproperty
    a_ctrl_routing: assert property (p_ctrl_routing)
        else $error("control register changed under another instruction");
    property p_data_routing;
        @(posedge i_tck) disable iff (rst_tck)
        (tap_state == TAP_UPDATE_DR && sel_data) |=> (tog_data != $past(tog_data))
            && (data_hold == $past(dr_shift[DATA_W-1:0]));
    endproperty
    a_data_routing: assert property (p_data_routing)
        else $error("data update not signalled");

    ////////////////////////////////////////////////////////////////////////////
    // System domain: synchronisers and bus transfer

    logic [SY_W-1:0] sy_meta, sy_s, sy_d;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [DATA_W-1:0] ctrl, next_ctrl;
    logic [DATA_W-1:0] next_mdb;
    logic addr_pend, next_addr_pend;
    logic wr_pend, next_wr_pend;
    logic next_rd_tog;
    mem_req_s next_mem;
    logic rise, fall, rw_read, do_wr, do_rd, apply_addr;
    logic ev_addr, ev_data, ev_ctrl;

    assign ev_addr = sy_s[SY_ADDR] ^ sy_d[SY_ADDR];
    assign ev_data = sy_s[SY_DATA] ^ sy_d[SY_DATA];
    assign ev_ctrl = sy_s[SY_CTRL] ^ sy_d[SY_CTRL];
    assign rise = sy_s[SY_TEST_CLOCK_PHASE] & ~sy_d[SY_TEST_CLOCK_PHASE];
    assign fall = ~sy_s[SY_TEST_CLOCK_PHASE] & sy_d[SY_TEST_CLOCK_PHASE];
    assign rw_read = ctrl[CTRL_RW_BIT];

    always_comb begin
        // Address only moves while the phase is low
        apply_addr = (addr_pend | ev_addr) & ~sy_s[SY_TEST_CLOCK_PHASE];
        // Data shifted while the phase is high is stored on the falling edge
        do_wr = wr_pend & ~rw_read & sy_s[SY_D2A] & (rise | fall);
        do_rd = rise & rw_read & sy_s[SY_D2A];
        next_addr = apply_addr ? addr_hold : addr;
        next_addr_pend = (addr_pend | ev_addr) & ~apply_addr;
        next_ctrl = ev_ctrl ? ctrl_hold : ctrl;
        // A new data word arriving with a store keeps its own pending flag
        next_wr_pend = ev_data | (wr_pend & ~do_wr);
        next_mdb = o_mdb;
        next_rd_tog = rd_tog;
        if (o_mem.rd) begin
            next_mdb = i_mem_rdata;
            next_rd_tog = ~rd_tog;
        end else if (ev_data) begin
            next_mdb = data_hold;
        end
        next_mem.addr = next_addr;
        next_mem.wdata = ev_data ? data_hold : o_mem.wdata;
        next_mem.wr = do_wr;
        next_mem.rd = do_rd;
        next_mem.byte_sel = next_ctrl[CTRL_BYTE_BIT];
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sy_meta <= '0;
            sy_s <= '0;
            sy_d <= '0;
            addr <= ADDR_ZERO;
            ctrl <= CTRL_RESET;
            o_mdb <= DATA_ZERO;
            addr_pend <= 1'b0;
            wr_pend <= 1'b0;
            rd_tog <= 1'b0;
            o_mem <= '0;
        end else begin
            sy_meta <= {d2a, test_clock_phase, tog_ctrl, tog_data, tog_addr};
            sy_s <= sy_meta;
            sy_d <= sy_s;
            addr <= next_addr;
            ctrl <= next_ctrl;
            o_mdb <= next_mdb;
            addr_pend <= next_addr_pend;
            wr_pend <= next_wr_pend;
            rd_tog <= next_rd_tog;
            o_mem <= next_mem;
        end
    end

    assign o_test_clock_phase = sy_s[SY_TEST_CLOCK_PHASE];
    assign o_debug_hold = ctrl[CTRL_HOLD_BIT];

    property p_read_capture;
        @(posedge i_clk_sys) disable iff (i_rst)
        o_mem.rd |=> (o_mdb == $past(i_mem_rdata)) && (rd_tog != $past(rd_tog));
    endproperty
    a_read_capture: assert property (p_read_capture)
        else $error("read data not placed on data bus");
    property p_read_start;
        @(posedge i_clk_sys) disable iff (i_rst)
        (rise && rw_read && sy_s[SY_D2A]) |=> o_mem.rd ##1 !o_mem.rd;
    endproperty
    a_read_start: assert property (p_read_start)
        else $error("rising phase did not start one read");
    property p_read_select;
        @(posedge i_clk_sys) disable iff (i_rst)
        o_mem.rd |-> $past(ctrl[CTRL_RW_BIT]) && !o_mem.wr;
    endproperty
    a_read_select: assert property (p_read_select)
        else $error("read issued while write selected");
    property p_write_select;
        @(posedge i_clk_sys) disable iff (i_rst)
        o_mem.wr |-> !$past(ctrl[CTRL_RW_BIT]) && $past(wr_pend);
    endproperty
    a_write_select: assert property (p_write_select)
        else $error("write issued without pending data or write select");
    property p_write_edge;
        @(posedge i_clk_sys) disable iff (i_rst)
        (rise && wr_pend && !rw_read && sy_s[SY_D2A]) |=> o_mem.wr && (o_mem.wdata == o_mdb);
    endproperty
    a_write_edge: assert property (p_write_edge)
        else $error("rising phase did not store pending data");
    // The phase level that gated the update is the one sampled one cycle back
    property p_addr_low;
        @(posedge i_clk_sys) disable iff (i_rst)
        (o_mem.addr != $past(o_mem.addr)) |-> !$past(sy_s[SY_TEST_CLOCK_PHASE]);
    endproperty
    a_addr_low: assert property (p_addr_low)
        else $error("address changed while phase high");
    property p_addr_apply;
        @(posedge i_clk_sys) disable iff (i_rst)
        (ev_addr && !sy_s[SY_TEST_CLOCK_PHASE]) |=> (o_mem.addr == $past(addr_hold));
    endproperty
    a_addr_apply: assert property (p_addr_apply)
        else $error("address not presented while phase low");
    property p_hold_follow;
        @(posedge i_clk_sys) disable iff (i_rst)
        ev_ctrl |=> (o_debug_hold == $past(ctrl_hold[CTRL_HOLD_BIT]))
            && (o_mem.byte_sel == $past(ctrl_hold[CTRL_BYTE_BIT]));
    endproperty
    a_hold_follow: assert property (p_hold_follow)
        else $error("control word not applied");

endmodule // jtag_memory_bus_access

// file: verilog/jtag_tap_fsm.sv
`timescale 1ns/10ps
module jtag_tap_fsm
    import jtag_mem_pkg::*;
(
    input wire logic i_tck,
    input wire logic i_rst_tck,
    input wire logic i_tms,
    output tap_state_e o_state
);

    tap_state_e state;
    tap_state_e next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            TAP_RESET: next_state = i_tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: next_state = i_tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: next_state = i_tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: next_state = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: next_state = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: next_state = i_tms ? TAP_UPDATE_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: next_state = i_tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: next_state = i_tms ? TAP_UPDATE_DR : TAP_SHIFT_DR;
            TAP_UPDATE_DR: next_state = i_tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: next_state = i_tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: next_state = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: next_state = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: next_state = i_tms ? TAP_UPDATE_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: next_state = i_tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: next_state = i_tms ? TAP_UPDATE_IR : TAP_SHIFT_IR;
            TAP_UPDATE_IR: next_state = i_tms ? TAP_SEL_DR : TAP_IDLE;
            // Recover from a corrupted one-hot code
            default: next_state = TAP_RESET;
        endcase
    end

    always_ff @(posedge i_tck) begin
        if (i_rst_tck) begin
            state <= TAP_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign o_state = state;

endmodule // jtag_tap_fsm
